// >>> pf_detect_filter.sv
// consecutive-scan filter for protective field detections
`timescale 1ns/1ns
`default_nettype none
module pf_detect_filter
    import pf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scan_valid,
    input wire logic detect,
    input wire logic [CNT_W-1:0] scans_needed,
    output logic infringed
);
    logic [CNT_W-1:0] cnt;
    wire [CNT_W-1:0] cnt_inc = cnt + 5'h01;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            infringed <= 1'b0;
        end else if (scan_valid) begin
            if (!detect) begin
                cnt <= '0;
                infringed <= 1'b0;
            end else if (cnt_inc >= scans_needed) begin
                cnt <= scans_needed;
                infringed <= 1'b1;
            end else begin
                cnt <= cnt_inc;
            end
        end
    end
endmodule
`default_nettype wire

// >>> pf_fault_log.sv
// circular fault memory for diagnosis reads
`timescale 1ns/1ns
`default_nettype none
module pf_fault_log
    import pf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fault_valid,
    input wire logic [7:0] fault_code,
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_code,
    output logic [3:0] count
);
    logic [7:0] mem [FAULT_DEPTH];
    logic [2:0] wptr;
    // oldest entries are overwritten once full; count saturates
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= '0;
            count <= '0;
            rd_code <= '0;
        end else begin
            if (fault_valid) begin
                wptr <= wptr + 3'h1;
                if (count != 4'(FAULT_DEPTH)) begin
                    count <= count + 4'h1;
                end
            end
            rd_code <= mem[rd_idx];
        end
    end
    always_ff @(posedge clk) begin
        if (fault_valid) begin
            mem[wptr] <= fault_code;
        end
    end
endmodule
`default_nettype wire

// >>> pf_pkg.sv
// shared constants of the restart control
// ============================================================
// Summary of operation
// - Inhibit mode keeps outputs off until field clear and restart pressed.
// - Immediate mode turns outputs on at the first scan while the filter shows no infringement.
// - Delayed mode waits set seconds of clear field, restarted by any infringement.
// - Start-up test bit is read only on leaving reset, while still 0, so readiness is never held off.
// - An infringement needs the set 2 to 16 consecutive detecting scans.
// - An upload with address zero is accepted by any unit.
// - Address 1 to 99 uploads are accepted only on a stored-address match.
// - Operator level may read but config and field writes are refused.
// - Config and field writes need a logon with the client credential.
// - Teach-in stores the contour measured while active as the boundary.
// - Detected faults go to a fault memory readable over the link.
// - A setting picks stationary or vehicle-mounted protection.
// - Both outputs go protective whenever an infringement is reported.
// - Alert follows its chosen cause, or blinks 4 a second on test error.
// - Boundary fields are kept until overwritten; configuration returns to its defaults on reset.
package pf_pkg;
    // ============================================================
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_DELAY = 8'h04;
    localparam logic [7:0] OFS_UNIT_ADDR = 8'h08;
    localparam logic [7:0] OFS_LOGON = 8'h0c;
    localparam logic [7:0] OFS_UPLOAD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TEACH = 8'h18;
    localparam logic [7:0] OFS_BOUND_IDX = 8'h1c;
    localparam logic [7:0] OFS_BOUND_DATA = 8'h20;
    localparam logic [7:0] OFS_FAULT_IDX = 8'h24;
    localparam logic [7:0] OFS_FAULT_DATA = 8'h28;
    // ============================================================
    // restart modes and alert selections
    localparam logic [1:0] RST_INHIBIT = 2'h0;
    localparam logic [1:0] RST_IMMEDIATE = 2'h1;
    localparam logic [1:0] RST_DELAYED = 2'h2;
    localparam logic [1:0] ALERT_EITHER = 2'h0;
    localparam logic [1:0] ALERT_WARN = 2'h1;
    localparam logic [1:0] ALERT_CONTAM = 2'h2;
    // ============================================================
    // field layout and limits
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] SCAN_MIN = 5'h02;
    localparam logic [CNT_W-1:0] SCAN_MAX = 5'h10;
    localparam logic [6:0] ADDR_UNIVERSAL = 7'h00;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    localparam int BOUND_DEPTH = 16;
    localparam int FAULT_DEPTH = 8;
    // ============================================================
    // reset values
    localparam logic [1:0] DEF_MODE = RST_INHIBIT;
    localparam logic [CNT_W-1:0] DEF_SCANS = SCAN_MIN;
    localparam logic [7:0] DEF_DELAY = 8'h02;
    // value is arbitrary
    localparam logic [31:0] DEF_CREDENTIAL = 32'h5a3c96e1;
    // ============================================================
    // 125 ms tick drives blink and seconds
    localparam longint CLK_HZ = 25000000;
    localparam longint TICK_MS = 125;
    localparam int TICK_CYCLES_DEF = int'(CLK_HZ * TICK_MS / 1000);
    localparam logic [2:0] TICKS_PER_SEC = 3'h7;
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_STARTUP = 3'b001,
        ST_STARTUP_CLR = 3'b010,
        ST_OFF = 3'b011,
        ST_DELAY = 3'b100,
        ST_ON = 3'b101
    } pf_state_e;
endpackage

// >>> pf_props.sv
// concurrent checks on the restart control block ports
`timescale 1ns/1ns
`default_nettype none
module pf_props
    import pf_pkg::*;
#(
    parameter logic [31:0] CREDENTIAL = DEF_CREDENTIAL
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire logic SCAN_VALID,
    input wire logic PROT_DETECT,
    input wire logic WARN_DETECT,
    input wire logic CONTAMINATED,
    input wire logic SELFTEST_ERR,
    input wire logic SAFETY_SWITCH_OUTPUT_A,
    input wire logic SAFETY_SWITCH_OUTPUT_B,
    input wire logic ALERT,
    input wire logic VEHICLE_MODE
);
    // ============================================================
    // shadow state
    logic [31:0] cfg;
    logic auth;
    logic [4:0] run;
    wire acc = PSEL && PENABLE && PWRITE;
    wire setup = PSEL && !PENABLE;
    wire prot = PADDR inside {OFS_CONFIG, OFS_DELAY, OFS_UNIT_ADDR, OFS_TEACH};
    wire bad = PADDR[1:0] != 2'h0 || PADDR > OFS_FAULT_DATA;
    wire [4:0] want = cfg[12:8] < SCAN_MIN ? SCAN_MIN :
        cfg[12:8] > SCAN_MAX ? SCAN_MAX : cfg[12:8];
    wire [1:0] sel = cfg[5:4];
    wire ea = sel == ALERT_WARN ? WARN_DETECT :
        sel == ALERT_CONTAM ? CONTAMINATED : WARN_DETECT | CONTAMINATED;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg <= 32'h200;
            auth <= 1'h0;
            run <= 5'h0;
        end else begin
            if (acc && !PSLVERR && PADDR == OFS_CONFIG) cfg <= PWDATA;
            if (acc && PADDR == OFS_LOGON) auth <= PWDATA == CREDENTIAL;
            if (SCAN_VALID) run <= PROT_DETECT ? run + 5'h1 : 5'h0;
        end
    end
    // ============================================================
    // assertions
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    drop_on_hit_a:
        assert property (SCAN_VALID && PROT_DETECT && run == want - 5'h1
            |-> ##[1:2] !SAFETY_SWITCH_OUTPUT_A) else $error("no drop");
    no_early_drop_a:
        assert property ($fell(SAFETY_SWITCH_OUTPUT_A) |-> run >= want)
        else $error("early drop");
    outputs_pair_a:
        assert property (SAFETY_SWITCH_OUTPUT_A == SAFETY_SWITCH_OUTPUT_B)
        else $error("channels differ");
    write_refused_a:
        assert property (setup && PWRITE && prot && !auth |=> PSLVERR)
        else $error("write not refused");
    write_taken_a:
        assert property (setup && PWRITE && prot && auth |=> !PSLVERR)
        else $error("good write refused");
    unmapped_err_a:
        assert property (setup && bad |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped not flagged");
    alert_follow_a:
        assert property (!$past(SELFTEST_ERR) |-> ALERT == $past(ea))
        else $error("alert mismatch");
    vehicle_bit_a:
        assert property (VEHICLE_MODE == $past(cfg[3]))
        else $error("vehicle mismatch");
    cover property (SCAN_VALID && PROT_DETECT && run == want - 5'h1);
    cover property ($rose(SAFETY_SWITCH_OUTPUT_A));
    cover property (setup && PWRITE && prot && !auth);
    cover property (SELFTEST_ERR && $rose(ALERT));
endmodule
bind pf_restart_ctrl pf_props #(.CREDENTIAL(CREDENTIAL)) chk_u (
    .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .SCAN_VALID(SCAN_VALID), .PROT_DETECT(PROT_DETECT),
    .WARN_DETECT(WARN_DETECT), .CONTAMINATED(CONTAMINATED),
    .SELFTEST_ERR(SELFTEST_ERR), .ALERT(ALERT), .VEHICLE_MODE(VEHICLE_MODE),
    .SAFETY_SWITCH_OUTPUT_A(SAFETY_SWITCH_OUTPUT_A),
    .SAFETY_SWITCH_OUTPUT_B(SAFETY_SWITCH_OUTPUT_B));
`default_nettype wire

// >>> pf_relay_model.sv
// safety relay with its restart button
`timescale 1ns/1ns
`default_nettype none
module pf_relay_model (
    input wire logic clk,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic press,
    output logic restart,
    output logic closed
);
    int hold = 0;
    // held so the pin synchroniser sees one clean press
    always @(posedge clk) begin
        if (press) hold <= 4;
        else if (hold > 0) hold <= hold - 1;
    end
    assign restart = hold > 0;
    // contacts close only while both channels are on
    assign closed = out_a && out_b;
endmodule
`default_nettype wire

// >>> pf_restart_ctrl.sv
// protective field restart control with apb configuration port
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pf_restart_ctrl
    import pf_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter logic [31:0] CREDENTIAL = DEF_CREDENTIAL
)
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SCAN_VALID,
    input wire logic PROT_DETECT,
    input wire logic WARN_DETECT,
    input wire logic CONTAMINATED,
    input wire logic SELFTEST_ERR,
    input wire logic RESTART,
    input wire logic CONTOUR_VALID,
    input wire logic [3:0] CONTOUR_SEG,
    input wire logic [15:0] CONTOUR_RANGE,
    input wire logic FAULT_VALID,
    input wire logic [7:0] FAULT_CODE,
    output logic SAFETY_SWITCH_OUTPUT_A,
    output logic SAFETY_SWITCH_OUTPUT_B,
    output logic ALERT,
    output logic READY,
    output logic VEHICLE_MODE
);
    // ============================================================
    // reset release and restart pin synchroniser
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    logic restart_meta;
    logic restart_sync;
    logic restart_prev;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            restart_meta <= 1'b0;
            restart_sync <= 1'b0;
            restart_prev <= 1'b0;
        end else begin
            restart_meta <= RESTART;
            restart_sync <= restart_meta;
            restart_prev <= restart_sync;
        end
    end
    wire restart_press = restart_sync && !restart_prev;

    // ============================================================
    // configuration registers
    logic [1:0] restart_mode;
    logic startup_test;
    logic vehicle;
    logic [1:0] alert_sel;
    logic [CNT_W-1:0] scans_needed;
    logic [7:0] delay_sec;
    logic [6:0] unit_addr;
    logic authorised;
    logic upload_ok;
    logic upload_rej;
    logic teach_on;
    logic [3:0] bound_idx;
    logic [2:0] fault_idx;
    logic [15:0] boundary [BOUND_DEPTH];

    // ============================================================
    // apb decode
    function automatic logic is_protected(input logic [7:0] a);
        is_protected = (a == OFS_CONFIG) || (a == OFS_DELAY) ||
            (a == OFS_UNIT_ADDR) || (a == OFS_TEACH);
    endfunction
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = is_protected(a) || (a == OFS_LOGON) ||
            (a == OFS_UPLOAD) || (a == OFS_STATUS) ||
            (a == OFS_BOUND_IDX) || (a == OFS_BOUND_DATA) ||
            (a == OFS_FAULT_IDX) || (a == OFS_FAULT_DATA);
    endfunction

    wire setup = PSEL && !PENABLE;
    wire access = PSEL && PENABLE;
    wire write_refused = PWRITE && is_protected(PADDR) &&
        !authorised;
    wire bad_access = !is_mapped(PADDR) || write_refused;
    wire wr_en = access && PWRITE && !PSLVERR;
    wire wr_cfg = wr_en && (PADDR == OFS_CONFIG);
    wire wr_delay = wr_en && (PADDR == OFS_DELAY);
    wire wr_addr = wr_en && (PADDR == OFS_UNIT_ADDR);
    wire wr_logon = wr_en && (PADDR == OFS_LOGON);
    wire wr_upload = wr_en && (PADDR == OFS_UPLOAD);
    wire wr_teach = wr_en && (PADDR == OFS_TEACH);
    wire wr_bidx = wr_en && (PADDR == OFS_BOUND_IDX);
    wire wr_fidx = wr_en && (PADDR == OFS_FAULT_IDX);

    wire [CNT_W-1:0] scans_wr = PWDATA[12:8];
    wire [CNT_W-1:0] scans_clamped = (scans_wr < SCAN_MIN) ? SCAN_MIN :
        (scans_wr > SCAN_MAX) ? SCAN_MAX : scans_wr;
    wire [6:0] upload_addr = PWDATA[6:0];
    wire addr_match = (upload_addr == ADDR_UNIVERSAL) ||
        ((upload_addr <= ADDR_MAX) && (upload_addr == unit_addr));
    wire upload_accept = addr_match && authorised;

    // ============================================================
    // filter, fault memory, timebase
    logic infringed;
    logic [7:0] fault_rd;
    logic [3:0] fault_cnt;
    pf_detect_filter u_filter (
        .clk(CLK),
        .rst_n(rst_n),
        .scan_valid(SCAN_VALID),
        .detect(PROT_DETECT),
        .scans_needed(scans_needed),
        .infringed(infringed)
    );
    pf_fault_log u_faults (
        .clk(CLK),
        .rst_n(rst_n),
        .fault_valid(FAULT_VALID),
        .fault_code(FAULT_CODE),
        .rd_idx(fault_idx),
        .rd_code(fault_rd),
        .count(fault_cnt)
    );

    logic [31:0] tick_cnt;
    logic [2:0] sub_sec;
    logic tick;
    logic sec_tick;
    logic blink;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            sub_sec <= '0;
            tick <= 1'b0;
            sec_tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            sec_tick <= tick && (sub_sec == TICKS_PER_SEC);
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 :
                tick_cnt + 32'h1;
            if (tick) begin
                sub_sec <= sub_sec + 3'h1;
            end
        end
    end

    // ============================================================
    // register writes; values persist until rewritten or reset to defaults
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            restart_mode <= DEF_MODE;
            startup_test <= 1'b0;
            vehicle <= 1'b0;
            alert_sel <= ALERT_EITHER;
            scans_needed <= DEF_SCANS;
            delay_sec <= DEF_DELAY;
            unit_addr <= ADDR_UNIVERSAL;
        end else begin
            if (wr_cfg) begin
                restart_mode <= PWDATA[1:0];
                startup_test <= PWDATA[2];
                vehicle <= PWDATA[3];
                alert_sel <= PWDATA[5:4];
                scans_needed <= scans_clamped;
            end
            if (wr_delay) begin
                delay_sec <= PWDATA[7:0];
            end
            if (wr_addr) begin
                unit_addr <= PWDATA[6:0];
            end
        end
    end

    // operator level after reset; a wrong credential logs off
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            authorised <= 1'b0;
            upload_ok <= 1'b0;
            upload_rej <= 1'b0;
            teach_on <= 1'b0;
            bound_idx <= '0;
            fault_idx <= '0;
        end else begin
            if (wr_logon) begin
                authorised <= (PWDATA == CREDENTIAL);
            end
            if (wr_upload) begin
                upload_ok <= upload_accept;
                upload_rej <= !upload_accept;
            end
            if (wr_teach) begin
                teach_on <= PWDATA[0];
            end
            if (wr_bidx) begin
                bound_idx <= PWDATA[3:0];
            end
            if (wr_fidx) begin
                fault_idx <= PWDATA[2:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (teach_on && CONTOUR_VALID) begin
            boundary[CONTOUR_SEG] <= CONTOUR_RANGE;
        end
    end

    // ============================================================
    // restart state machine, evaluated every clock cycle
    pf_state_e state;
    pf_state_e next_state;
    logic [7:0] sec_cnt;
    logic restart_pend;
    wire field_clear = !infringed;
    always_comb begin
        next_state = state;
        case (state)
            ST_INIT: begin
                next_state = startup_test ? ST_STARTUP : ST_OFF;
            end
            ST_STARTUP: begin
                if (SCAN_VALID && infringed) begin
                    next_state = ST_STARTUP_CLR;
                end
            end
            ST_STARTUP_CLR: begin
                if (SCAN_VALID && field_clear) begin
                    next_state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (SCAN_VALID && field_clear) begin
                    case (restart_mode)
                        RST_IMMEDIATE: next_state = ST_ON;
                        RST_DELAYED: next_state = ST_DELAY;
                        default: begin
                            if (restart_pend) begin
                                next_state = ST_ON;
                            end
                        end
                    endcase
                end
            end
            ST_DELAY: begin
                if (infringed) begin
                    next_state = ST_OFF;
                end else if (sec_cnt >= delay_sec) begin
                    next_state = ST_ON;
                end
            end
            ST_ON: begin
                if (infringed) begin
                    next_state = ST_OFF;
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    // a press counts only while the field is clear in the blocked state
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_INIT;
            sec_cnt <= '0;
            restart_pend <= 1'b0;
        end else begin
            state <= next_state;
            if (state != ST_DELAY) begin
                sec_cnt <= '0;
            end else if (sec_tick && sec_cnt != 8'hff) begin
                sec_cnt <= sec_cnt + 8'h1;
            end
            if (state != ST_OFF || infringed) begin
                restart_pend <= 1'b0;
            end else if (restart_press) begin
                restart_pend <= 1'b1;
            end
        end
    end

    // ============================================================
    // outputs
    wire outputs_on = (next_state == ST_ON) && !infringed;
    wire alert_cond = (alert_sel == ALERT_WARN) ? WARN_DETECT :
        (alert_sel == ALERT_CONTAM) ? CONTAMINATED :
        (WARN_DETECT || CONTAMINATED);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SAFETY_SWITCH_OUTPUT_A <= 1'b0;
            SAFETY_SWITCH_OUTPUT_B <= 1'b0;
            ALERT <= 1'b0;
            blink <= 1'b0;
            READY <= 1'b0;
            VEHICLE_MODE <= 1'b0;
        end else begin
            SAFETY_SWITCH_OUTPUT_A <= outputs_on;
            SAFETY_SWITCH_OUTPUT_B <= outputs_on;
            if (tick) begin
                blink <= !blink;
            end
            ALERT <= SELFTEST_ERR ? blink : alert_cond;
            READY <= (state != ST_INIT) && (state != ST_STARTUP) &&
                (state != ST_STARTUP_CLR);
            VEHICLE_MODE <= vehicle;
        end
    end

    // ============================================================
    // read data captured in the setup cycle, zero-wait access phase
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        case (PADDR)
            OFS_CONFIG: rd_mux = {19'h0, scans_needed, 2'h0, alert_sel,
                vehicle, startup_test, restart_mode};
            OFS_DELAY: rd_mux = {24'h0, delay_sec};
            OFS_UNIT_ADDR: rd_mux = {25'h0, unit_addr};
            OFS_LOGON: rd_mux = {31'h0, authorised};
            OFS_UPLOAD: rd_mux = {30'h0, upload_rej, upload_ok};
            OFS_STATUS: rd_mux = {25'h0, state, ALERT, READY, infringed,
                SAFETY_SWITCH_OUTPUT_A};
            OFS_TEACH: rd_mux = {31'h0, teach_on};
            OFS_BOUND_IDX: rd_mux = {28'h0, bound_idx};
            OFS_BOUND_DATA: rd_mux = {16'h0, boundary[bound_idx]};
            OFS_FAULT_IDX: rd_mux = {29'h0, fault_idx};
            OFS_FAULT_DATA: rd_mux = {20'h0, fault_cnt, fault_rd};
            default: rd_mux = '0;
        endcase
    end

    assign PREADY = 1'b1;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA <= PWRITE ? '0 : rd_mux;
            PSLVERR <= bad_access;
        end else if (!PSEL) begin
            PSLVERR <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the restart control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pf_pkg::*;
    logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic sv = 1'h0, det = 1'h0, warn = 1'h0, contam = 1'h0, sterr = 1'h0;
    logic cv = 1'h0, fv = 1'h0, press = 1'h0, pa = 1'h0;
    logic [7:0] paddr = 8'h0, fcode = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] cseg = 4'h0;
    logic [15:0] crng = 16'h0;
    logic pready, pslverr, oa, ob, alert, rst_btn, closed, veh_seen;
    logic [31:0] ul[4] = '{32'h0, 32'h5, 32'h6, 32'h64};
    logic [31:0] ua[4] = '{32'h1, 32'h1, 32'h2, 32'h2};
    int fails = 0, comparisons = 0, tg;
    pf_restart_ctrl #(.TICK_CYCLES(4)) dut_u (.CLK(clk), .ARST_N(arst_n),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SCAN_VALID(sv), .PROT_DETECT(det),
        .WARN_DETECT(warn), .CONTAMINATED(contam), .SELFTEST_ERR(sterr),
        .RESTART(rst_btn), .CONTOUR_VALID(cv), .CONTOUR_SEG(cseg),
        .CONTOUR_RANGE(crng), .FAULT_VALID(fv), .FAULT_CODE(fcode),
        .SAFETY_SWITCH_OUTPUT_A(oa), .SAFETY_SWITCH_OUTPUT_B(ob),
        .ALERT(alert), .READY(), .VEHICLE_MODE(veh_seen));
    pf_relay_model relay_u (.clk(clk), .out_a(oa), .out_b(ob),
        .press(press), .restart(rst_btn), .closed(closed));
    // ============================================================
    // bus and scan tasks
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rly(input logic e);
        chk("relay", {31'h0, e}, {31'h0, closed});
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] e, input logic err);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        chk("prdata", e, prdata);
        chk("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic scans(input logic d, input int n);
        repeat (n) begin
            @(posedge clk);
            sv <= 1'h1;
            det <= d;
            @(posedge clk);
            sv <= 1'h0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic results;
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ============================================================
    // tests
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #1200000;
        fails++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        xfer(1'h0, OFS_CONFIG, 32'h0, 32'h200, 1'h0);
        xfer(1'h0, OFS_DELAY, 32'h0, 32'h2, 1'h0);
        xfer(1'h0, 8'h40, 32'h0, 32'h0, 1'h1);
        xfer(1'h1, OFS_CONFIG, 32'h301, 32'h0, 1'h1);
        xfer(1'h0, OFS_CONFIG, 32'h0, 32'h200, 1'h0);
        xfer(1'h1, OFS_LOGON, 32'h1, 32'h0, 1'h0);
        xfer(1'h0, OFS_LOGON, 32'h0, 32'h0, 1'h0);
        xfer(1'h1, OFS_LOGON, DEF_CREDENTIAL, 32'h0, 1'h0);
        xfer(1'h0, OFS_LOGON, 32'h0, 32'h1, 1'h0);
        xfer(1'h1, OFS_UNIT_ADDR, 32'h5, 32'h0, 1'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'h1, OFS_UPLOAD, ul[i], 32'h0, 1'h0);
            xfer(1'h0, OFS_UPLOAD, 32'h0, ua[i], 1'h0);
        end
        xfer(1'h1, OFS_CONFIG, 32'h301, 32'h0, 1'h0);
        scans(1'h0, 2);
        rly(1'h1);
        scans(1'h1, 2);
        scans(1'h0, 1);
        scans(1'h1, 2);
        rly(1'h1);
        scans(1'h1, 1);
        rly(1'h0);
        scans(1'h0, 2);
        rly(1'h1);
        scans(1'h1, 3);
        xfer(1'h1, OFS_CONFIG, 32'h300, 32'h0, 1'h0);
        scans(1'h0, 3);
        rly(1'h0);
        @(posedge clk);
        press <= 1'h1;
        @(posedge clk);
        press <= 1'h0;
        repeat (6) @(posedge clk);
        scans(1'h0, 2);
        rly(1'h1);
        scans(1'h1, 3);
        xfer(1'h1, OFS_DELAY, 32'h3, 32'h0, 1'h0);
        xfer(1'h1, OFS_CONFIG, 32'h302, 32'h0, 1'h0);
        scans(1'h0, 5);
        rly(1'h0);
        scans(1'h1, 3);
        scans(1'h0, 5);
        rly(1'h0);
        scans(1'h0, 30);
        rly(1'h1);
        scans(1'h1, 3);
        for (int s = 0; s < 3; s++) begin
            xfer(1'h1, OFS_CONFIG, 32'h308 | (s << 4), 32'h0, 1'h0);
            for (int w = 0; w < 4; w++) begin
                {warn, contam} <= w[1:0];
                repeat (3) @(posedge clk);
                pa = s == 1 ? w[1] : s == 2 ? w[0] : |w[1:0];
                chk("alert", {31'h0, pa}, {31'h0, alert});
            end
            chk("vehicle", 32'h1, {31'h0, veh_seen});
        end
        sterr <= 1'h1;
        tg = 0;
        repeat (64) begin
            @(posedge clk);
            if (alert !== pa) tg++;
            pa = alert;
        end
        chk("blink", 32'h1, {31'h0, tg inside {[15:17]}});
        sterr <= 1'h0;
        xfer(1'h1, OFS_TEACH, 32'h1, 32'h0, 1'h0);
        @(posedge clk);
        cv <= 1'h1;
        cseg <= 4'h3;
        crng <= 16'h1234;
        @(posedge clk);
        cv <= 1'h0;
        xfer(1'h1, OFS_TEACH, 32'h0, 32'h0, 1'h0);
        xfer(1'h1, OFS_BOUND_IDX, 32'h3, 32'h0, 1'h0);
        xfer(1'h0, OFS_BOUND_DATA, 32'h0, 32'h1234, 1'h0);
        @(posedge clk);
        fv <= 1'h1;
        fcode <= 8'ha5;
        @(posedge clk);
        fcode <= 8'h3c;
        @(posedge clk);
        fv <= 1'h0;
        xfer(1'h1, OFS_FAULT_IDX, 32'h1, 32'h0, 1'h0);
        xfer(1'h0, OFS_FAULT_DATA, 32'h0, 32'h23c, 1'h0);
        results();
    end
endmodule
`default_nettype wire
